// ---- rtl/mtc_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mtc_map.svh"

module mtc_checker
	import mtc_pkg::*;
#(
	parameter logic [15:0] READ_MAX = `MTC_READ_MAX,
	parameter logic [15:0] WRITE_MAX = `MTC_WRITE_MAX
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// query side
	input wire mtc_query_t qry,
	output logic qry_ready,
	input wire logic server_busy,
	// register directory
	output mtc_lookup_t look,
	input wire mtc_attr_t attr,
	// walked registers and final verdict
	output mtc_step_t step,
	output mtc_verdict_t verdict,
	// exception frame bytes
	output logic [7:0] resp_byte,
	output logic resp_valid,
	output logic resp_last,
	input wire logic resp_ready
);

	mtc_chk_t r_reg;
	mtc_chk_t r_next;
	logic frame_done;

	// words a profile object may still take from the quantity left
	function automatic logic [15:0] fn_take(logic [3:0] words,
		logic [15:0] left);
		logic [15:0] w;
		w = (words == 4'h0) ? 16'h0001 : {12'h000, words};
		return (w > left) ? left : w;
	endfunction

	// function codes this block serves
	function automatic logic fn_served(logic [7:0] f);
		logic s;
		s = (f == `MTC_FC_READ) || (f == `MTC_FC_WRITE);
		return s;
	endfunction

	// zero or above the limit; the limit keeps one answer in one frame
	function automatic logic fn_qty_bad(logic [7:0] f, logic [15:0] q);
		logic [15:0] qmax;
		qmax = (f == `MTC_FC_WRITE) ? WRITE_MAX : READ_MAX;
		return (q == 16'h0000) || (q > qmax);
	endfunction

	// register can be served in the direction of the query
	function automatic logic fn_usable(mtc_attr_t a, logic wr);
		logic u;
		u = a.exists && (wr ? a.writable : a.readable);
		return u;
	endfunction

	// served written register whose new value is refused
	function automatic logic fn_bad_value(mtc_attr_t a, logic wr);
		logic b;
		b = fn_usable(a, wr) && wr && !a.value_ok;
		return b;
	endfunction

	// walk ends once the words taken use up the quantity left
	function automatic mtc_state_t fn_after(logic [15:0] left,
		logic [15:0] take);
		mtc_state_t s;
		s = (left == take) ? ST_DONE : ST_ASK;
		return s;
	endfunction

	// exception frames leave through the byte serialiser
	mtc_framer u_framer (
		.clock(clock),
		.rst_n(rst_n),
		.go(r_reg.go),
		.hdr(r_reg.hdr),
		.frame_done(frame_done),
		.resp_byte(resp_byte),
		.resp_valid(resp_valid),
		.resp_last(resp_last),
		.resp_ready(resp_ready)
	);

	// main sequence: take query, walk directory, judge, frame
	always_comb
	begin
		logic ok;
		logic prof;
		logic [15:0] take;
		ok = 1'b0;
		prof = 1'b0;
		take = 16'h0000;
		r_next = r_reg;
		r_next.look.req = 1'b0;
		r_next.step.valid = 1'b0;
		r_next.verdict.done = 1'b0;
		r_next.go = 1'b0;
		case (r_reg.st)
			ST_IDLE:
			begin
				if (qry.valid)
				begin
					// clear every walk flag left by the previous query
					r_next.q = qry;
					r_next.addr = qry.start;
					r_next.left = qry.qty;
					r_next.idx = 16'h0000;
					r_next.first_words = 16'h0000;
					r_next.write = qry.func == `MTC_FC_WRITE;
					r_next.profile = 1'b0;
					r_next.objs = 1'b0;
					r_next.second = 1'b0;
					r_next.multi = 1'b0;
					r_next.gap = 1'b0;
					r_next.any_ok = 1'b0;
					r_next.data_bad = 1'b0;
					r_next.pre = 1'b0;
					r_next.code = 8'h00;
					// a foreign protocol id is dropped without a frame
					if (qry.pid != `MTC_PID_MODBUS)
					begin
						r_next.verdict.done = 1'b1;
						r_next.verdict.silent = 1'b1;
						r_next.verdict.exc = 1'b0;
						r_next.verdict.code = 8'h00;
						r_next.verdict.commit_words = 16'h0000;
					end
					// function first, then busy, then the walk
					else if (!fn_served(qry.func))
					begin
						r_next.pre = 1'b1;
						r_next.code = `MTC_EXC_FUNC;
						r_next.st = ST_DONE;
					end
					else if (server_busy)
					begin
						r_next.pre = 1'b1;
						r_next.code = `MTC_EXC_BUSY;
						r_next.st = ST_DONE;
					end
					// zero or oversized quantity is bad data
					else if (fn_qty_bad(qry.func, qry.qty))
					begin
						r_next.pre = 1'b1;
						r_next.code = `MTC_EXC_DATA;
						r_next.st = ST_DONE;
					end
					else
						r_next.st = ST_ASK;
				end
			end
			ST_ASK:
			begin
				// one lookup per plain word or per profile object
				r_next.look.req = 1'b1;
				r_next.look.addr = r_reg.addr;
				r_next.st = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (attr.valid)
				begin
					// the first answer decides profile or plain walk
					prof = (r_reg.idx == 16'h0000) ? attr.profile : r_reg.profile;
					r_next.profile = prof;
					ok = fn_usable(attr, r_reg.write);
					if (!prof)
					begin
						// one register per word; misses only clear keep
						r_next.any_ok = r_reg.any_ok | ok;
						if (fn_bad_value(attr, r_reg.write))
							r_next.data_bad = 1'b1;
						r_next.step.valid = 1'b1;
						r_next.step.addr = r_reg.addr;
						r_next.step.index = r_reg.idx;
						r_next.step.words = 4'h1;
						r_next.step.keep = ok;
						r_next.addr = r_reg.addr + 16'h0001;
						r_next.idx = r_reg.idx + 16'h0001;
						r_next.left = r_reg.left - 16'h0001;
						r_next.st = fn_after(r_reg.left, 16'h0001);
					end
					else if (!attr.exists)
					begin
						// missing object, also a hole between two objects
						r_next.gap = 1'b1;
						r_next.st = ST_DONE;
					end
					else
					begin
						// one object per step, it may span several words
						take = fn_take(attr.words, r_reg.left);
						r_next.any_ok = r_reg.any_ok | ok;
						r_next.multi = r_reg.multi | attr.multi_sub;
						r_next.objs = 1'b1;
						if (!r_reg.objs)
							r_next.first_words = take;
						else
							r_next.second = 1'b1;
						if (fn_bad_value(attr, r_reg.write))
							r_next.data_bad = 1'b1;
						r_next.step.valid = 1'b1;
						r_next.step.addr = r_reg.addr;
						r_next.step.index = r_reg.idx;
						r_next.step.words = take[3:0];
						r_next.step.keep = ok;
						r_next.addr = r_reg.addr + 16'h0001;
						r_next.idx = r_reg.idx + take;
						r_next.left = r_reg.left - take;
						r_next.st = fn_after(r_reg.left, take);
					end
				end
			end
			ST_DONE:
			begin
				// the first flag that matches picks the code
				r_next.verdict.done = 1'b1;
				r_next.verdict.silent = 1'b0;
				r_next.verdict.exc = 1'b1;
				r_next.verdict.commit_words = 16'h0000;
				if (r_reg.pre)
					r_next.verdict.code = r_reg.code;
				else if (r_reg.profile && r_reg.gap)
					r_next.verdict.code = `MTC_EXC_ADDR;
				else if (r_reg.profile && r_reg.second && r_reg.multi)
				begin
					// the first object is still written in full
					r_next.verdict.code = `MTC_EXC_ADDR;
					if (r_reg.write)
						r_next.verdict.commit_words = r_reg.first_words;
				end
				else if (!r_reg.any_ok)
					r_next.verdict.code = `MTC_EXC_ADDR;
				// address problems are reported before data ones
				else if (r_reg.data_bad)
					r_next.verdict.code = `MTC_EXC_DATA;
				else
				begin
					r_next.verdict.exc = 1'b0;
					r_next.verdict.code = 8'h00;
					r_next.verdict.commit_words = r_reg.q.qty;
				end
				r_next.hdr.tid = r_reg.q.tid;
				r_next.hdr.unit = r_reg.q.unit;
				r_next.hdr.func = r_reg.q.func;
				r_next.hdr.code = r_next.verdict.code;
				r_next.go = r_next.verdict.exc;
				r_next.st = r_next.verdict.exc ? ST_FRAME : ST_IDLE;
			end
			ST_FRAME:
			begin
				// hold off new queries until the frame has left
				if (frame_done)
					r_next.st = ST_IDLE;
			end
			default:
				r_next.st = ST_IDLE;
		endcase
		r_next.ready = r_next.st == ST_IDLE;
	end

	// state register; reset clears every field, ready included
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	// every output but the frame byte stream is a field of the state register
	assign qry_ready = r_reg.ready;
	assign look = r_reg.look;
	assign step = r_reg.step;
	assign verdict = r_reg.verdict;

endmodule
`default_nettype wire

// ---- rtl/mtc_map.svh ----
`ifndef MTC_MAP_SVH
`define MTC_MAP_SVH

// function codes served by this block
`define MTC_FC_READ 8'h03
`define MTC_FC_WRITE 8'h10
// flag or-ed into the function code of an exception answer
`define MTC_FC_EXC_FLAG 8'h80

// exception codes
`define MTC_EXC_FUNC 8'h01
`define MTC_EXC_ADDR 8'h02
`define MTC_EXC_DATA 8'h03
`define MTC_EXC_BUSY 8'h06

// header values of an exception frame
`define MTC_PID_MODBUS 16'h0000
`define MTC_EXC_LEN 16'h0003
`define MTC_FRAME_LAST 4'h8

// quantity limits per query
`define MTC_READ_MAX 16'h007d
`define MTC_WRITE_MAX 16'h007b

`endif

// ---- rtl/mtc_pkg.sv ----
`default_nettype none

package mtc_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ASK = 3'b001,
		ST_WAIT = 3'b010,
		ST_DONE = 3'b011,
		ST_FRAME = 3'b100
	} mtc_state_t;

	// parsed query, one-cycle valid
	typedef struct packed {
		logic valid;
		logic [15:0] tid;
		logic [15:0] pid;
		logic [7:0] unit;
		logic [7:0] func;
		logic [15:0] start;
		logic [15:0] qty;
	} mtc_query_t;

	// answer of the register directory for one address
	typedef struct packed {
		logic valid;
		logic exists;
		logic readable;
		logic writable;
		logic profile;
		logic multi_sub;
		logic [3:0] words;
		logic value_ok;
	} mtc_attr_t;

	typedef struct packed {
		logic req;
		logic [15:0] addr;
	} mtc_lookup_t;

	// one walked register or profile object
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] index;
		logic [3:0] words;
		logic keep;
	} mtc_step_t;

	typedef struct packed {
		logic done;
		logic silent;
		logic exc;
		logic [7:0] code;
		logic [15:0] commit_words;
	} mtc_verdict_t;

	// fields echoed into an exception frame
	typedef struct packed {
		logic [15:0] tid;
		logic [7:0] unit;
		logic [7:0] func;
		logic [7:0] code;
	} mtc_hdr_t;

	typedef struct packed {
		logic busy;
		logic valid;
		logic last;
		logic done;
		logic [7:0] data;
		logic [3:0] idx;
		mtc_hdr_t hdr;
	} mtc_frm_t;

	typedef struct packed {
		mtc_state_t st;
		mtc_query_t q;
		logic [15:0] addr;
		logic [15:0] left;
		logic [15:0] idx;
		logic [15:0] first_words;
		logic write;
		logic profile;
		logic objs;
		logic second;
		logic multi;
		logic gap;
		logic any_ok;
		logic data_bad;
		logic pre;
		logic [7:0] code;
		logic ready;
		logic go;
		mtc_lookup_t look;
		mtc_step_t step;
		mtc_verdict_t verdict;
		mtc_hdr_t hdr;
	} mtc_chk_t;

endpackage

`default_nettype wire

// ---- rtl/mtc_framer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mtc_map.svh"

module mtc_framer
	import mtc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// frame request
	input wire logic go,
	input wire mtc_hdr_t hdr,
	output logic frame_done,
	// byte stream
	output logic [7:0] resp_byte,
	output logic resp_valid,
	output logic resp_last,
	input wire logic resp_ready
);

	mtc_frm_t r_reg;
	mtc_frm_t r_next;

	// byte at position idx of a nine-byte exception frame
	function automatic logic [7:0] fn_byte(mtc_hdr_t h, logic [3:0] idx);
		logic [15:0] len;
		logic [15:0] pid;
		logic [7:0] b;
		len = `MTC_EXC_LEN;
		pid = `MTC_PID_MODBUS;
		case (idx)
			4'h0: b = h.tid[15:8];
			4'h1: b = h.tid[7:0];
			4'h2: b = pid[15:8];
			4'h3: b = pid[7:0];
			4'h4: b = len[15:8];
			4'h5: b = len[7:0];
			4'h6: b = h.unit;
			4'h7: b = h.func | `MTC_FC_EXC_FLAG;
			4'h8: b = h.code;
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	// new frames are taken only when idle; the checker waits for done
	always_comb
	begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (!r_reg.busy)
		begin
			if (go)
			begin
				r_next.hdr = hdr;
				r_next.idx = 4'h0;
				r_next.busy = 1'b1;
				r_next.valid = 1'b1;
				r_next.last = 1'b0;
				r_next.data = fn_byte(hdr, 4'h0);
			end
		end
		else if (r_reg.valid && resp_ready)
		begin
			if (r_reg.idx == `MTC_FRAME_LAST)
			begin
				r_next.busy = 1'b0;
				r_next.valid = 1'b0;
				r_next.last = 1'b0;
				r_next.done = 1'b1;
			end
			else
			begin
				r_next.idx = r_reg.idx + 4'h1;
				r_next.data = fn_byte(r_reg.hdr, r_reg.idx + 4'h1);
				r_next.last = (r_reg.idx + 4'h1) == `MTC_FRAME_LAST;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign resp_byte = r_reg.data;
	assign resp_valid = r_reg.valid;
	assign resp_last = r_reg.last;
	assign frame_done = r_reg.done;

endmodule
`default_nettype wire

// ---- test/mtc_checker_properties.sv ----
`timescale 1ns/10ps
`default_nettype none

module mtc_checker_props
	import mtc_pkg::*;
#(
	parameter logic [15:0] READ_MAX = 16'h007d,
	parameter logic [15:0] WRITE_MAX = 16'h007b
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// query side
	input wire mtc_query_t qry,
	input wire logic qry_ready,
	input wire logic server_busy,
	// verdict and frame
	input wire mtc_verdict_t verdict,
	input wire logic [7:0] resp_byte,
	input wire logic resp_valid,
	input wire logic resp_last,
	input wire logic resp_ready
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic take;
	logic fok;
	logic [3:0] cnt_reg;
	logic [15:0] tid_reg;
	logic [7:0] func_reg;

	// a query taken with a valid protocol id, and a served function code
	assign take = qry.valid && qry_ready && qry.pid == 16'h0000;
	assign fok = qry.func == 8'h03 || qry.func == 8'h10;

	// frame byte position, plus the fields the frame must echo
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= 4'h0;
			tid_reg <= 16'h0000;
			func_reg <= 8'h00;
		end
		else
		begin
			if (take)
			begin
				tid_reg <= qry.tid;
				func_reg <= qry.func;
			end
			if (resp_valid && resp_ready)
				cnt_reg <= resp_last ? 4'h0 : cnt_reg + 4'h1;
		end
	end

	property p_pid_silent;
		qry.valid && qry_ready && qry.pid != 16'h0000 |=> verdict.done && verdict.silent;
	endproperty
	a_pid_silent: assert property (p_pid_silent)
		else $error("nonzero protocol id not dropped");
	property p_func01;
		take && !fok |-> ##2 verdict.done && verdict.exc && verdict.code == 8'h01;
	endproperty
	a_func01: assert property (p_func01)
		else $error("unsupported function not answered 01");
	property p_busy06;
		take && fok && server_busy |-> ##2 verdict.done && verdict.code == 8'h06;
	endproperty
	a_busy06: assert property (p_busy06)
		else $error("busy server not answered 06");
	property p_qty03;
		take && fok && !server_busy && (qry.qty == 16'h0000 ||
		qry.qty > (qry.func == 8'h03 ? READ_MAX : WRITE_MAX))
		|-> ##2 verdict.done && verdict.code == 8'h03;
	endproperty
	a_qty03: assert property (p_qty03)
		else $error("bad quantity not answered 03");
	property p_frame_start;
		verdict.done && verdict.exc |-> ##2 resp_valid;
	endproperty
	a_frame_start: assert property (p_frame_start)
		else $error("exception frame did not start");
	property p_tid_echo;
		resp_valid && cnt_reg == 4'h0 |-> resp_byte == tid_reg[15:8];
	endproperty
	a_tid_echo: assert property (p_tid_echo)
		else $error("transaction id not echoed");
	property p_func_flag;
		resp_valid && cnt_reg == 4'h7 |-> resp_byte == (func_reg | 8'h80);
	endproperty
	a_func_flag: assert property (p_func_flag)
		else $error("function byte lacks flag");
	property p_frame_last;
		resp_valid |-> resp_last == (cnt_reg == 4'h8);
	endproperty
	a_frame_last: assert property (p_frame_last)
		else $error("frame length wrong");

	c_frame: cover property (resp_valid && resp_last && resp_ready);
	c_silent: cover property (verdict.done && verdict.silent);
	c_ok: cover property (verdict.done && !verdict.exc && !verdict.silent);
endmodule

bind mtc_checker mtc_checker_props #(.READ_MAX(READ_MAX), .WRITE_MAX(WRITE_MAX))
	u_props (.clock(clock), .rst_n(rst_n), .qry(qry), .qry_ready(qry_ready),
	.server_busy(server_busy), .verdict(verdict), .resp_byte(resp_byte),
	.resp_valid(resp_valid), .resp_last(resp_last), .resp_ready(resp_ready));

`default_nettype wire

// ---- test/mtc_dir_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module mtc_dir_model
	import mtc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// directory lookup
	input wire mtc_lookup_t look,
	output mtc_attr_t attr
);
	logic [1:0] wait_reg;
	logic busy_reg;

	// tiny directory: 0101 missing, 0102 read only, 6045 a gap
	function automatic mtc_attr_t attr_of(input logic [15:0] a);
		mtc_attr_t r;
		r = '0;
		r.valid = 1'b1;
		r.profile = a[15:12] == 4'h6;
		r.value_ok = a != 16'h0104;
		r.multi_sub = a == 16'h6048 || a == 16'h6049 || a == 16'h6099;
		r.words = r.multi_sub ? (a == 16'h6048 ? 4'h4 : 4'h3) : 4'h1;
		case (a)
			16'h0100, 16'h0103, 16'h0104, 16'h6044, 16'h6046, 16'h6048,
			16'h6049, 16'h6098, 16'h6099, 16'h609a:
				{r.exists, r.readable, r.writable} = 3'b111;
			16'h0102: {r.exists, r.readable} = 2'b11;
			default: r.exists = 1'b0;
		endcase
		return r;
	endfunction

	// answer after a random delay; between answers the fields show junk
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			attr <= '0;
			busy_reg <= 1'b0;
			wait_reg <= 2'b00;
		end
		else if (busy_reg && wait_reg == 2'b00)
		begin
			attr <= attr_of(look.addr);
			busy_reg <= 1'b0;
		end
		else
		begin
			attr <= {1'b0, ~attr[9:0]};
			if (busy_reg)
				wait_reg <= wait_reg - 2'b01;
			if (look.req)
			begin
				busy_reg <= 1'b1;
				wait_reg <= 2'($urandom);
			end
		end
	end
endmodule

`default_nettype wire

// ---- test/tb_mtc_checker.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_mtc_checker;
	import mtc_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic server_busy = 1'b0;
	logic resp_ready = 1'b1;
	logic qry_ready, resp_valid, resp_last;
	logic [7:0] resp_byte;
	mtc_query_t qry = '0;
	mtc_lookup_t look;
	mtc_attr_t attr;
	mtc_verdict_t verdict, got;
	mtc_step_t step;
	logic [7:0] cur_f = 8'h00;
	logic [7:0] fq[$];
	int failures = 0;
	int n_checks = 0;
	logic [15:0] s, n;

	always #25 clock = ~clock;

	mtc_checker dut (.clock(clock), .rst_n(rst_n), .qry(qry),
		.qry_ready(qry_ready), .server_busy(server_busy), .look(look),
		.attr(attr), .step(step), .verdict(verdict), .resp_byte(resp_byte),
		.resp_valid(resp_valid), .resp_last(resp_last),
		.resp_ready(resp_ready));
	mtc_dir_model dir (.clock(clock), .rst_n(rst_n), .look(look), .attr(attr));

	// gather accepted frame bytes and the last verdict
	always @(posedge clock)
	begin
		if (resp_valid && resp_ready)
			fq.push_back(resp_byte);
		if (verdict.done)
			got = verdict;
		if (step.valid)
			chk(step.keep, exp_keep(step.addr, cur_f == 8'h10));
	end

	// sink stalls now and then so bytes must hold
	always @(negedge clock)
		resp_ready <= ($urandom & 3) != 0;

	task automatic finish_test;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// first argument is the design's value, second the expected one
	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		n_checks++;
		if (a !== e)
		begin
			failures++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask

	// plain reads fail only when the one word asked for is missing
	function automatic logic [7:0] exp_rd(input logic [15:0] a, input logic [15:0] q);
		return (a == 16'h0101 && q == 16'h0001) ? 8'h02 : 8'h00;
	endfunction

	// registers the partner can serve in the direction asked
	function automatic logic exp_keep(input logic [15:0] a, input logic wr);
		logic k;
		case (a)
			16'h0100, 16'h0103, 16'h0104, 16'h6044, 16'h6046, 16'h6048,
			16'h6049, 16'h6098, 16'h6099, 16'h609a:
				k = 1'b1;
			16'h0102: k = !wr;
			default: k = 1'b0;
		endcase
		return k;
	endfunction

	// one query; cw 16'hffff means the commit count is not judged
	task automatic run(input logic [7:0] f, input logic [15:0] a,
		input logic [15:0] q, input logic bz, input logic [15:0] pid,
		input logic [7:0] code, input logic [15:0] cw);
		int i;
		logic [15:0] tid;
		logic [7:0] u;
		logic [71:0] ef;
		logic [2:0] ev;
		tid = 16'($urandom);
		u = 8'($urandom);
		i = 0;
		while (!qry_ready && i < 400)
		begin
			@(negedge clock);
			i++;
		end
		fq.delete();
		got = '0;
		cur_f = f;
		qry <= {1'b1, tid, pid, u, f, a, q};
		server_busy <= bz;
		@(negedge clock);
		qry.valid <= 1'b0;
		// ready and the verdict may land on one edge; wait for both
		i = 0;
		while (!(qry_ready && got.done) && i < 2000)
		begin
			@(negedge clock);
			i++;
		end
		ev = {1'b1, pid != 16'h0000, code != 8'h00};
		chk({got.done, got.silent, got.exc}, ev);
		chk(got.code, code);
		if (cw != 16'hffff)
			chk(got.commit_words, cw);
		ef = {tid, 32'h00000003, u, f | 8'h80, code};
		chk(fq.size(), code != 8'h00 ? 9 : 0);
		for (i = 0; i < 9 && code != 8'h00; i++)
			chk(fq[i], ef[71 - 8 * i -: 8]);
	endtask

	initial
	begin
		#(50 * 60000);
		failures++;
		finish_test();
	end

	initial
	begin
		void'($urandom(32'ha001b942));
		repeat (10) @(negedge clock);
		rst_n <= 1'b1;
		run(8'h03, 16'h0100, 16'h0002, 1'b0, 16'h0001, 8'h00, 16'hffff);
		run(8'h05, 16'h0100, 16'h0000, 1'b1, 16'h0000, 8'h01, 16'hffff);
		run(8'h03, 16'h0100, 16'h0000, 1'b1, 16'h0000, 8'h06, 16'hffff);
		run(8'h10, 16'h0100, 16'h0000, 1'b0, 16'h0000, 8'h03, 16'hffff);
		run(8'h03, 16'h0100, 16'h007e, 1'b0, 16'h0000, 8'h03, 16'hffff);
		run(8'h10, 16'h0100, 16'h007c, 1'b0, 16'h0000, 8'h03, 16'hffff);
		run(8'h03, 16'h0100, 16'h007d, 1'b0, 16'h0000, 8'h00, 16'h007d);
		run(8'h10, 16'h0100, 16'h0004, 1'b0, 16'h0000, 8'h00, 16'h0004);
		run(8'h03, 16'h0200, 16'h0002, 1'b0, 16'h0000, 8'h02, 16'hffff);
		run(8'h10, 16'h0102, 16'h0001, 1'b0, 16'h0000, 8'h02, 16'hffff);
		run(8'h10, 16'h0103, 16'h0002, 1'b0, 16'h0000, 8'h03, 16'hffff);
		run(8'h03, 16'h6044, 16'h0002, 1'b0, 16'h0000, 8'h02, 16'hffff);
		run(8'h10, 16'h6044, 16'h0002, 1'b0, 16'h0000, 8'h02, 16'h0000);
		run(8'h03, 16'h6045, 16'h0001, 1'b0, 16'h0000, 8'h02, 16'hffff);
		run(8'h10, 16'h6048, 16'h0004, 1'b0, 16'h0000, 8'h00, 16'h0004);
		run(8'h10, 16'h6048, 16'h0007, 1'b0, 16'h0000, 8'h02, 16'h0004);
		run(8'h10, 16'h6098, 16'h0004, 1'b0, 16'h0000, 8'h02, 16'h0001);
		run(8'h10, 16'h6099, 16'h0004, 1'b0, 16'h0000, 8'h02, 16'h0003);
		run(8'h03, 16'h6048, 16'h0007, 1'b0, 16'h0000, 8'h02, 16'h0000);
		repeat (20)
		begin
			s = 16'h0100 + 16'($urandom % 4);
			n = 16'h0001 + 16'($urandom % 4);
			run(8'h03, s, n, 1'b0, 16'h0000, exp_rd(s, n),
				exp_rd(s, n) == 8'h00 ? n : 16'h0000);
		end
		finish_test();
	end
endmodule

`default_nettype wire
